/* File: hdl/chb_target.sv */
// Purpose: peripheral end of the compact multiplexed host bus
// Assumes: host pins are asynchronous to CLK and pass three flip-flops
// Notes: slot side is a plain request/done handshake on CLK
// ==========================================================
module chb_target #(
	parameter logic [23:0] ADDR_BASE = 24'h00_03e0,
	parameter logic [23:0] ADDR_MASK = 24'hff_fff0,
	parameter int REQ_W = 8
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [15:0] MUXED_HOST_BUS_I,
	output logic [15:0] MUXED_HOST_BUS_O,
	output logic MUXED_HOST_BUS_OE,
	input wire logic HOST_BUS_CLOCK,
	input wire logic ALE,
	input wire logic CMD_N,
	input wire logic BUS_RESET,
	output logic SELECT_BACKOFF_N_O,
	output logic SELECT_BACKOFF_N_OE,
	output logic READY_O,
	output logic READY_OE,
	input wire logic SPEAKER_IN,
	output logic SPEAKER_OUT,
	input wire logic [REQ_W-1:0] IRQ_PEND,
	input wire logic [REQ_W-1:0] DRQ_PEND,
	output logic SLOT_REQ,
	output chb_pkg::chb_slot_req_t SLOT_CYCLE,
	input wire logic SLOT_DONE,
	input wire logic [15:0] SLOT_RDATA
);
	// ==========================================================
	// pin synchronisers
	function automatic logic [chb_pkg::SYNC_W-1:0] agree(
		input logic [chb_pkg::SYNC_W-1:0] s2,
		input logic [chb_pkg::SYNC_W-1:0] s3,
		input logic [chb_pkg::SYNC_W-1:0] held
	);
		agree = (s2 & s3) | (held & (s2 ^ s3));
	endfunction

	logic [chb_pkg::SYNC_W-1:0] sy1_reg, sy2_reg, sy3_reg, filt_reg, prev_reg;
	wire [chb_pkg::SYNC_W-1:0] pins = {SPEAKER_IN, BUS_RESET, CMD_N, ALE, HOST_BUS_CLOCK,
		MUXED_HOST_BUS_I};
	wire [chb_pkg::SYNC_W-1:0] filt_next = agree(sy2_reg, sy3_reg, filt_reg);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sy1_reg <= chb_pkg::SYNC_RST;
			sy2_reg <= chb_pkg::SYNC_RST;
			sy3_reg <= chb_pkg::SYNC_RST;
			filt_reg <= chb_pkg::SYNC_RST;
			prev_reg <= chb_pkg::SYNC_RST;
		end else begin
			sy1_reg <= pins;
			sy2_reg <= sy1_reg;
			sy3_reg <= sy2_reg;
			filt_reg <= filt_next;
			prev_reg <= filt_reg;
		end
	end

	wire [15:0] bus_f = filt_reg[15:0];
	wire ale_f = filt_reg[chb_pkg::SY_ALE];
	wire cmd_f = !filt_reg[chb_pkg::SY_CMD];
	wire rst_f = filt_reg[chb_pkg::SY_RST];
	wire hclk_rise = filt_reg[chb_pkg::SY_HCLK] & !prev_reg[chb_pkg::SY_HCLK];
	wire ale_rise = ale_f & !prev_reg[chb_pkg::SY_ALE];
	wire ale_fall = !ale_f & prev_reg[chb_pkg::SY_ALE];
	// bus reset joins the local reset
	wire rst = !RST_N | rst_f;

	// ==========================================================
	// cycle sequencer
	chb_pkg::chb_state_t state_reg, state_next;
	logic [15:0] addr_lo_reg;
	logic [15:0] phase2_reg;
	logic [15:0] wdata_reg, rdata_reg;
	logic claim_reg;
	logic [2:0] cnt_reg;

	wire [23:0] addr_full = {phase2_reg[chb_pkg::PH2_ADDR_LSB +: 8], addr_lo_reg};
	wire [23:0] addr_now = {bus_f[chb_pkg::PH2_ADDR_LSB +: 8], addr_lo_reg};
	wire claim_now = (addr_now & ADDR_MASK) == ADDR_BASE;
	wire chb_pkg::chb_cmd_t cmd_code = chb_pkg::chb_cmd_t'(phase2_reg[chb_pkg::PH2_CMD_LSB +: 3]);
	wire is_read = (cmd_code == chb_pkg::CMD_IO_RD) || (cmd_code == chb_pkg::CMD_MEM_RD);
	wire pending = |{IRQ_PEND, DRQ_PEND};

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			chb_pkg::ST_IDLE: begin
				// phase two moves the cycle on
				if (ale_rise) begin
					state_next = chb_pkg::ST_CLAIM;
				end else if (!ale_f && pending && !cmd_f) begin
					state_next = chb_pkg::ST_BACKOFF;
				end
			end
			chb_pkg::ST_CLAIM: begin
				if (ale_fall) begin
					state_next = claim_reg ? chb_pkg::ST_DATA : chb_pkg::ST_IDLE;
				end
			end
			chb_pkg::ST_DATA: begin
				// the host strobe opens the data phase
				if (cmd_f) begin
					state_next = chb_pkg::ST_SLOT;
				end
			end
			chb_pkg::ST_SLOT: begin
				if (SLOT_DONE) begin
					state_next = chb_pkg::ST_HOLD;
				end
			end
			chb_pkg::ST_HOLD: begin
				if (!cmd_f) begin
					state_next = chb_pkg::ST_IDLE;
				end
			end
			chb_pkg::ST_BACKOFF: begin
				if (ale_rise) begin
					state_next = chb_pkg::ST_CLAIM;
				end else if (cmd_f) begin
					state_next = chb_pkg::ST_DRIVE;
				end else if (!pending) begin
					state_next = chb_pkg::ST_IDLE;
				end
			end
			chb_pkg::ST_DRIVE: begin
				if (cnt_reg == 3'h0) begin
					state_next = chb_pkg::ST_DRWAIT;
				end
			end
			chb_pkg::ST_DRWAIT: begin
				if (!cmd_f) begin
					state_next = chb_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = chb_pkg::ST_IDLE;
			end
		endcase
		if (rst) begin
			state_next = chb_pkg::ST_IDLE;
		end
	end

	// word driven back, requests in both bytes
	wire [15:0] drive_word = {8'(DRQ_PEND), 8'(IRQ_PEND)};
	wire enter_slot = (state_reg == chb_pkg::ST_DATA) && (state_next == chb_pkg::ST_SLOT);
	wire enter_drive = (state_reg != chb_pkg::ST_DRIVE) && (state_next == chb_pkg::ST_DRIVE);
	wire claim_reg_next = (state_reg != chb_pkg::ST_CLAIM) ? claim_now : claim_reg;
	wire sel_next = (state_next == chb_pkg::ST_CLAIM && claim_reg_next) ||
		(state_next == chb_pkg::ST_BACKOFF);
	// ready low extends the slot access
	// ready low then high paces the drive-back
	wire rdy_drive_next = (state_next == chb_pkg::ST_SLOT) || (state_next == chb_pkg::ST_HOLD) ||
		(state_next == chb_pkg::ST_DRIVE) || (state_next == chb_pkg::ST_DRWAIT);
	wire rdy_level_next = (state_next == chb_pkg::ST_HOLD) || (state_next == chb_pkg::ST_DRWAIT);
	wire bus_oe_next = (state_next == chb_pkg::ST_HOLD && is_read) ||
		(state_next == chb_pkg::ST_DRIVE) || (state_next == chb_pkg::ST_DRWAIT);
	wire [15:0] bus_o_next = (state_next == chb_pkg::ST_HOLD) ?
		(SLOT_DONE ? SLOT_RDATA : rdata_reg) : drive_word;

	always_ff @(posedge CLK) begin
		if (rst) begin
			state_reg <= chb_pkg::ST_IDLE;
			addr_lo_reg <= chb_pkg::BUS_RST;
			phase2_reg <= chb_pkg::BUS_RST;
			wdata_reg <= chb_pkg::BUS_RST;
			rdata_reg <= chb_pkg::BUS_RST;
			claim_reg <= 1'b0;
			cnt_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			// address phase on host clock rise
			if (hclk_rise && state_reg == chb_pkg::ST_IDLE) begin
				addr_lo_reg <= bus_f;
			end
			// address and command on ALE rise
			if (ale_rise && state_next == chb_pkg::ST_CLAIM) begin
				phase2_reg <= bus_f;
				claim_reg <= claim_now;
			end
			if (enter_slot) begin
				wdata_reg <= bus_f;
			end
			if (state_reg == chb_pkg::ST_SLOT && SLOT_DONE) begin
				rdata_reg <= SLOT_RDATA;
			end
			if (enter_drive) begin
				cnt_reg <= chb_pkg::DRIVEBACK_LOAD;
			end else if (cnt_reg != 3'h0) begin
				cnt_reg <= cnt_reg - 3'h1;
			end
		end
	end

	// ==========================================================
	// registered pins
	always_ff @(posedge CLK) begin
		if (rst) begin
			SELECT_BACKOFF_N_O <= 1'b1;
			SELECT_BACKOFF_N_OE <= 1'b0;
			READY_O <= 1'b1;
			READY_OE <= 1'b0;
			MUXED_HOST_BUS_O <= chb_pkg::BUS_RST;
			MUXED_HOST_BUS_OE <= 1'b0;
			SLOT_REQ <= 1'b0;
			SLOT_CYCLE <= '0;
		end else begin
			// shared line only ever tri-state driven
			SELECT_BACKOFF_N_O <= !sel_next;
			SELECT_BACKOFF_N_OE <= sel_next;
			READY_O <= rdy_level_next;
			READY_OE <= rdy_drive_next;
			MUXED_HOST_BUS_O <= bus_o_next;
			MUXED_HOST_BUS_OE <= bus_oe_next;
			// host cycle handed to the slot side
			SLOT_REQ <= enter_slot;
			if (enter_slot) begin
				SLOT_CYCLE <= '{addr: addr_full, cmd: cmd_code, wdata: bus_f};
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			SPEAKER_OUT <= 1'b0;
		end else begin
			SPEAKER_OUT <= filt_reg[chb_pkg::SY_SPK];
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	chk_claim_select: assert property (
		(state_reg == chb_pkg::ST_CLAIM && claim_reg) |-> SELECT_BACKOFF_N_OE && !SELECT_BACKOFF_N_O)
		else $error("claimed cycle without select");
	chk_backoff_drive: assert property (
		(state_reg == chb_pkg::ST_BACKOFF) |-> SELECT_BACKOFF_N_OE && !SELECT_BACKOFF_N_O)
		else $error("back-off request not driven");
	chk_idle_release: assert property (
		(state_reg == chb_pkg::ST_IDLE) |-> !SELECT_BACKOFF_N_OE && !READY_OE && !MUXED_HOST_BUS_OE)
		else $error("line driven while idle");
	chk_ready_extend: assert property (
		$rose(state_reg == chb_pkg::ST_SLOT) |-> READY_OE && !READY_O && SLOT_REQ)
		else $error("slot access not extended");
	chk_driveback_pace: assert property (
		$rose(state_reg == chb_pkg::ST_DRIVE) |-> (READY_OE && !READY_O)[*4]
		##1 (READY_OE && READY_O))
		else $error("drive-back pacing wrong");
	chk_phase_one: assert property (
		(!rst && hclk_rise && state_reg == chb_pkg::ST_IDLE) |=> addr_lo_reg == $past(bus_f))
		else $error("address phase not captured");
	chk_phase_two: assert property (
		(!rst && ale_rise && state_reg == chb_pkg::ST_IDLE) |=>
		state_reg == chb_pkg::ST_CLAIM && phase2_reg == $past(bus_f))
		else $error("second phase not latched");
	chk_bus_reset: assert property (
		rst_f |=> state_reg == chb_pkg::ST_IDLE && !SELECT_BACKOFF_N_OE && !READY_OE)
		else $error("bus reset did not idle");
	chk_speaker_follow: assert property (
		##1 SPEAKER_OUT == $past(filt_reg[chb_pkg::SY_SPK]))
		else $error("speaker not following");

	cov_claimed_cycle: cover property (SLOT_REQ ##[1:50] (state_reg == chb_pkg::ST_HOLD));
	cov_driveback: cover property ((state_reg == chb_pkg::ST_DRIVE) ##[1:20] READY_O);
	cov_unclaimed: cover property ((state_reg == chb_pkg::ST_CLAIM && !claim_reg)
		##[1:50] (state_reg == chb_pkg::ST_IDLE));
endmodule // chb_target

/* File: hdl/chb_pkg.sv */
// Purpose: shared constants and types of the compact host bus target
// Assumes: one 25 MHz clock, host pins sampled through synchronisers
// Notes: phase field positions are local choices
package chb_pkg;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int DRIVEBACK_NS = 160;
	// least time, rounded up
	localparam int DRIVEBACK_CYC = (DRIVEBACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] DRIVEBACK_LOAD = 3'(DRIVEBACK_CYC - 1);
	// ==========================================================
	// phase field and synchroniser bit positions
	localparam int PH2_ADDR_LSB = 8;
	localparam int PH2_CMD_LSB = 0;
	localparam int SYNC_W = 21;
	localparam int SY_HCLK = 16;
	localparam int SY_ALE = 17;
	localparam int SY_CMD = 18;
	localparam int SY_RST = 19;
	localparam int SY_SPK = 20;
	// ==========================================================
	// reset values
	localparam logic [15:0] BUS_RST = 16'h0000;
	localparam logic [SYNC_W-1:0] SYNC_RST = 21'h04_0000;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_DACK, CMD_RSV5, CMD_RSV6, CMD_RSV7
	} chb_cmd_t;
	typedef enum {
		ST_IDLE, ST_CLAIM, ST_DATA, ST_SLOT, ST_HOLD, ST_BACKOFF, ST_DRIVE, ST_DRWAIT
	} chb_state_t;
	typedef struct packed {
		logic [23:0] addr;
		chb_cmd_t cmd;
		logic [15:0] wdata;
	} chb_slot_req_t;
endpackage : chb_pkg

/* File: verif/chb_host_model.sv */
// Purpose: host chipset model facing the compact host bus target
// Assumes: pins move at the falling edge of CLK and each level holds at least 4 cycles
// Notes: released shared lines read high, a released bus reads the host's own drive
module chb_host_model (
	input wire logic clk,
	input wire logic [15:0] bus_o,
	input wire logic bus_oe,
	input wire logic sel_o,
	input wire logic sel_oe,
	input wire logic rdy_o,
	input wire logic rdy_oe,
	output logic [15:0] bus_i,
	output logic hclk,
	output logic ale,
	output logic cmd_n,
	output logic sel_w,
	output logic rdy_w
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] drv;
	int run = 0;
	int last_run = 0;
	// ==========================================================
	// wire levels
	// shared lines pulled high when released
	assign sel_w = sel_oe ? sel_o : 1'b1;
	assign rdy_w = rdy_oe ? rdy_o : 1'b1;
	assign bus_i = bus_oe ? bus_o : drv;
	initial begin
		drv = 16'h0000;
		hclk = 1'b0;
		ale = 1'b0;
		cmd_n = 1'b1;
	end
	// length of the last ready-low run
	always @(posedge clk) begin
		if (rdy_oe && !rdy_o) run <= run + 1;
		else if (run != 0) begin
			last_run <= run;
			run <= 0;
		end
	end
	// ==========================================================
	// cycles
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_rdy();
		for (int i = 0; i < 60 && rdy_w !== 1'b1; i++) hold(1);
	endtask
	// address, command and data phases in turn
	task automatic cycle(input logic [23:0] a, input logic [2:0] c, input logic [15:0] wd,
		output logic sel, output logic [15:0] rd);
		drv = a[15:0];
		hclk = 1'b1;
		hold(4);
		hclk = 1'b0;
		drv = {a[23:16], 5'h00, c};
		ale = 1'b1;
		// select appears one cycle after the filtered rise
		hold(6);
		sel = sel_w;
		ale = 1'b0;
		hold(4);
		drv = wd;
		cmd_n = 1'b0;
		hold(6);
		wait_rdy();
		rd = bus_i;
		cmd_n = 1'b1;
		drv = ~drv;
		hold(5);
	endtask
	task automatic ack(output logic [15:0] word);
		cmd_n = 1'b0;
		hold(6);
		wait_rdy();
		word = bus_i;
	endtask
	task automatic end_cmd();
		cmd_n = 1'b1;
		hold(5);
	endtask
endmodule // chb_host_model

/* File: verif/test_compact_host_bus_target.sv */
// Purpose: self-checking bench of the compact host bus target
// Assumes: host model drives pins, bench answers slot cycles
// Notes: slot answers SLOT_DLY cycles after a request
module test_compact_host_bus_target;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLOT_DLY = 3;
	logic CLK, RST_N, BUS_RESET, SPEAKER_IN, SLOT_DONE;
	logic [7:0] irq, drq;
	logic [15:0] rdval, bus_o, bus_i;
	logic bus_oe, sel_o, sel_oe, rdy_o, rdy_oe, hclk, ale, cmd_n, sel_w, rdy_w, spk, sreq;
	chb_pkg::chb_slot_req_t scyc, seen;
	int errors = 0;
	int checked = 0;
	int nreq = 0;
	int dly = 0;
	chb_target uut (.CLK(CLK), .RST_N(RST_N), .MUXED_HOST_BUS_I(bus_i),
		.MUXED_HOST_BUS_O(bus_o), .MUXED_HOST_BUS_OE(bus_oe), .HOST_BUS_CLOCK(hclk),
		.ALE(ale), .CMD_N(cmd_n), .BUS_RESET(BUS_RESET), .SELECT_BACKOFF_N_O(sel_o),
		.SELECT_BACKOFF_N_OE(sel_oe), .READY_O(rdy_o), .READY_OE(rdy_oe),
		.SPEAKER_IN(SPEAKER_IN), .SPEAKER_OUT(spk), .IRQ_PEND(irq), .DRQ_PEND(drq),
		.SLOT_REQ(sreq), .SLOT_CYCLE(scyc), .SLOT_DONE(SLOT_DONE), .SLOT_RDATA(rdval));
	chb_host_model host (.clk(CLK), .bus_o(bus_o), .bus_oe(bus_oe), .sel_o(sel_o),
		.sel_oe(sel_oe), .rdy_o(rdy_o), .rdy_oe(rdy_oe), .bus_i(bus_i), .hclk(hclk),
		.ale(ale), .cmd_n(cmd_n), .sel_w(sel_w), .rdy_w(rdy_w));
	// ==========================================================
	// clock and slot responder
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	always @(negedge CLK) begin
		SLOT_DONE <= (dly == 1);
		if (sreq === 1'b1) begin
			seen <= scyc;
			nreq <= nreq + 1;
			dly <= SLOT_DLY;
		end else if (dly > 0) dly <= dly - 1;
	end
	// ==========================================================
	// checks
	task automatic chk(input string what, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic chk_idle();
		chk("released", {bus_oe, sel_oe, rdy_oe}, 32'h0);
	endtask
	task automatic final_report();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_cycles();
		logic sel;
		logic [15:0] rd;
		logic [23:0] a;
		for (int c = 0; c < 4; c++) begin
			a = c[1] ? 24'h0003ef : 24'h0003e0;
			rdval = 16'h1230 + 16'(c);
			host.cycle(a, 3'(c), 16'hbee0 ^ 16'(c), sel, rd);
			chk("select", sel, 32'h0);
			chk("slot addr", seen.addr, a);
			chk("slot cmd", seen.cmd, c);
			if (c[0]) chk("slot wdata", seen.wdata, 16'hbee0 ^ 16'(c));
			else chk("read data", rd, rdval);
			chk("ready run", host.last_run, SLOT_DLY + 1);
			chk_idle();
		end
	endtask
	task automatic t_miss();
		logic sel;
		logic [15:0] rd;
		int n0;
		n0 = nreq;
		host.cycle(24'h0003f0, 3'h0, 16'h0000, sel, rd);
		chk("miss select", sel, 32'h1);
		host.cycle(24'h1003e0, 3'h1, 16'h0000, sel, rd);
		chk("miss select", sel, 32'h1);
		chk("miss slot", nreq, n0);
		chk_idle();
	endtask
	task automatic t_driveback(input logic [7:0] iv, input logic [7:0] dv);
		logic [15:0] w;
		irq = iv;
		drq = dv;
		host.hold(8);
		chk("backoff", sel_w, 32'h0);
		host.ack(w);
		chk("vector", w, {dv, iv});
		chk("pace", host.last_run, chb_pkg::DRIVEBACK_CYC);
		irq = 8'h00;
		drq = 8'h00;
		host.end_cmd();
		chk_idle();
	endtask
	task automatic t_busreset();
		drq = 8'h04;
		host.hold(8);
		chk("backoff", sel_w, 32'h0);
		BUS_RESET = 1'b1;
		host.hold(6);
		chk("reset sel", {sel_oe, rdy_oe, bus_oe}, 32'h0);
		BUS_RESET = 1'b0;
		host.hold(6);
		chk("again", sel_w, 32'h0);
		drq = 8'h00;
		host.hold(6);
		chk_idle();
	endtask
	task automatic t_speaker(input logic lvl);
		SPEAKER_IN = lvl;
		host.hold(6);
		chk("speaker", spk, 32'(lvl));
		SPEAKER_IN = !lvl;
		host.hold(6);
		chk("speaker", spk, 32'(!lvl));
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		RST_N = 1'b0;
		BUS_RESET = 1'b0;
		SPEAKER_IN = 1'b0;
		irq = 8'h00;
		drq = 8'h00;
		rdval = 16'h0000;
		host.hold(6);
		chk_idle();
		RST_N = 1'b1;
		host.hold(4);
		t_cycles();
		t_miss();
		t_driveback(8'h5a, 8'h81);
		t_driveback(8'h01, 8'h40);
		t_busreset();
		t_speaker(1'b1);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge CLK);
		errors++;
		final_report();
	end
endmodule // test_compact_host_bus_target
